// File: common/core_timer_regs.vh
// register offsets, field positions and reset values for the core timer block
`ifndef CORE_TIMER_REGS_VH
`define CORE_TIMER_REGS_VH

`define ADDR_CORE_COUNT   4'h0
`define ADDR_CORE_CTRL    4'h1
`define ADDR_AUX_COUNT    4'h2
`define ADDR_AUX_CTRL     4'h3
`define ADDR_CAPTURE_RELOAD_REG       4'h4

// core control register fields
`define CC_ISEL_LSB   0
`define CC_MODE_LSB   3
`define CC_RUN        6
`define CC_UD         7
`define CC_UDE        8
`define CC_OTL        9
`define CC_OE         10
`define CC_BPS_LSB    11
`define CC_RELOAD     13
// auxiliary control register fields
`define AC_RUN        6
`define AC_RRS        10
`define AC_CAP_EN     11

`define MODE_TIMER    3'h0
`define MODE_COUNTER  3'h1
`define MODE_GATE_LO  3'h2
`define MODE_GATE_HI  3'h3

`define CORE_CTRL_RST 16'h0000
`define AUX_CTRL_RST  16'h0000
`define BASE_PRESCALE_LOG2 4'h2

`endif

// File: hdl/core_timer.v
// core 16-bit timer with toggle latch, shadow latch and capture/reload
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/100ps
`include "core_timer_regs.vh"
module core_timer #(
   parameter WIDTH = 16
) (
   input  wire             CLK,
   input  wire             ARST_N,
   input  wire [3:0]       ADDR,
   input  wire [15:0]      WDATA,
   input  wire             WR,
   input  wire             RD,
   output reg  [15:0]      RDATA,
   input  wire             TIMER_IN,
   input  wire             EXT_UPDOWN,
   input  wire             CAPTURE_IN,
   output reg              TOGGLE_OUT,
   output reg              OVER_UNDER,
   output reg              TOGGLE_LATCH,
   output reg              SHADOW_LATCH,
   output reg              AUX_RUN
);

   // two-stage synchronisers for pins
   reg [1:0] tin_sync_reg;
   reg [1:0] eud_sync_reg;
   reg [1:0] cap_sync_reg;
   reg       tin_last_reg;
   reg       cap_last_reg;

   reg [15:0] count_reg;
   reg [15:0] aux_count_reg;
   reg [15:0] capture_reload_reg_reg;
   reg [15:0] ctrl_reg;
   reg [15:0] aux_ctrl_reg;
   reg [11:0] pre_reg;
   reg        shadow_reg;

   wire [2:0] isel = ctrl_reg[`CC_ISEL_LSB+2:`CC_ISEL_LSB];
   wire [2:0] mode = ctrl_reg[`CC_MODE_LSB+2:`CC_MODE_LSB];
   wire [1:0] bps  = ctrl_reg[`CC_BPS_LSB+1:`CC_BPS_LSB];
   wire       run  = ctrl_reg[`CC_RUN];
   wire       tin  = tin_sync_reg[1];
   wire       eud  = eud_sync_reg[1];

   // log2 of overall prescale; block field has non-linear encoding
   function [3:0] pre_log2;
      input [1:0] b;
      input [2:0] i;
      reg   [1:0] bl;
      begin
         case (b)
            2'h1:    bl = 2'h0;
            2'h0:    bl = 2'h1;
            2'h3:    bl = 2'h2;
            default: bl = 2'h3;
         endcase
         pre_log2 = `BASE_PRESCALE_LOG2 + {2'h0, bl} + {1'h0, i};
      end
   endfunction

   // direction: updown_bit alone, or pin xor updown_bit
   wire count_down = ctrl_reg[`CC_UDE] ? (eud ^ ctrl_reg[`CC_UD])
                                       : ctrl_reg[`CC_UD];

   // prescaler tick: msb-selected wrap of a free counter
   wire [3:0] plog   = pre_log2(bps, isel);
   wire [11:0] pmask = (12'hFFF >> (4'hC - plog)) ;
   wire tick = ((pre_reg & pmask) == pmask);

   // edge selection in counter mode; 1xx reserved counts nothing
   wire rise = tin & ~tin_last_reg;
   wire fall = ~tin & tin_last_reg;
   reg  edge_hit;
   always @* begin
      case (isel)
         3'h1:    edge_hit = rise;
         3'h2:    edge_hit = fall;
         3'h3:    edge_hit = rise | fall;
         default: edge_hit = 1'b0;
      endcase
   end

   // step enable by mode; gate change only affects counting (no irq logic)
   reg step;
   always @* begin
      case (mode)
         `MODE_TIMER:   step = run & tick;
         `MODE_COUNTER: step = run & edge_hit;
         `MODE_GATE_LO,
         `MODE_GATE_HI: step = run & tick & (tin == mode[0]);
         default:       step = 1'b0;
      endcase
   end

   wire wrap = step & (count_down ? (count_reg == 16'h0000) : (count_reg == 16'hFFFF));
   wire wr_count = WR & (ADDR == `ADDR_CORE_COUNT);
   wire wr_ctrl  = WR & (ADDR == `ADDR_CORE_CTRL);
   wire cap_edge = cap_sync_reg[1] ^ cap_last_reg;

   // synchronisers and prescaler
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         tin_sync_reg <= 2'h0;
         eud_sync_reg <= 2'h0;
         cap_sync_reg <= 2'h0;
         tin_last_reg <= 1'b0;
         cap_last_reg <= 1'b0;
         pre_reg      <= 12'h000;
      end else begin
         tin_sync_reg <= {tin_sync_reg[0], TIMER_IN};
         eud_sync_reg <= {eud_sync_reg[0], EXT_UPDOWN};
         cap_sync_reg <= {cap_sync_reg[0], CAPTURE_IN};
         tin_last_reg <= tin_sync_reg[1];
         cap_last_reg <= cap_sync_reg[1];
         pre_reg      <= pre_reg + 12'h001;
      end
   end

   // count, control, latches; cpu writes take priority over hardware
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         count_reg     <= 16'h0000;
         aux_count_reg <= 16'h0000;
         capture_reload_reg_reg    <= 16'h0000;
         ctrl_reg      <= `CORE_CTRL_RST;
         aux_ctrl_reg  <= `AUX_CTRL_RST;
         shadow_reg    <= 1'b0;
      end else begin
         if (wr_count)
            count_reg <= WDATA;
         else if (wrap & ctrl_reg[`CC_RELOAD])
            count_reg <= capture_reload_reg_reg;
         else if (step)
            count_reg <= count_down ? count_reg - 16'h0001 : count_reg + 16'h0001;
         if (wr_ctrl) begin
            ctrl_reg   <= WDATA;
            shadow_reg <= WDATA[`CC_OTL];
         end else begin
            if (wrap)
               ctrl_reg[`CC_OTL] <= ~ctrl_reg[`CC_OTL];
            shadow_reg <= ctrl_reg[`CC_OTL];
         end
         if (WR & (ADDR == `ADDR_AUX_CTRL))
            aux_ctrl_reg <= WDATA;
         if (WR & (ADDR == `ADDR_AUX_COUNT))
            aux_count_reg <= WDATA;
         if (WR & (ADDR == `ADDR_CAPTURE_RELOAD_REG))
            capture_reload_reg_reg <= WDATA;
         else if (aux_ctrl_reg[`AC_CAP_EN] & cap_edge)
            capture_reload_reg_reg <= aux_count_reg;
      end
   end

   // registered outputs and read data
   always @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         RDATA        <= 16'h0000;
         TOGGLE_OUT   <= 1'b1;
         OVER_UNDER   <= 1'b0;
         TOGGLE_LATCH <= 1'b0;
         SHADOW_LATCH <= 1'b0;
         AUX_RUN      <= 1'b0;
      end else begin
         case (ADDR)
            `ADDR_CORE_COUNT: RDATA <= RD ? count_reg : 16'h0000;
            `ADDR_CORE_CTRL:  RDATA <= RD ? ctrl_reg : 16'h0000;
            `ADDR_AUX_COUNT:  RDATA <= RD ? aux_count_reg : 16'h0000;
            `ADDR_AUX_CTRL:   RDATA <= RD ? aux_ctrl_reg : 16'h0000;
            `ADDR_CAPTURE_RELOAD_REG:     RDATA <= RD ? capture_reload_reg_reg : 16'h0000;
            default:          RDATA <= 16'h0000;
         endcase
         // high level when disabled keeps external logic idle
         TOGGLE_OUT   <= ctrl_reg[`CC_OE] ? ctrl_reg[`CC_OTL] : 1'b1;
         OVER_UNDER   <= wrap;
         TOGGLE_LATCH <= ctrl_reg[`CC_OTL];
         SHADOW_LATCH <= shadow_reg;
         AUX_RUN      <= aux_ctrl_reg[`AC_RRS] ? run : aux_ctrl_reg[`AC_RUN];
      end
   end

endmodule // core_timer

// File: tb/core_timer_assertions.sv
// port assertions for the core timer
`timescale 1ns/100ps
module core_timer_chk (
   input wire        CLK,
   input wire        ARST_N,
   input wire [3:0]  ADDR,
   input wire [15:0] WDATA,
   input wire        WR,
   input wire        RD,
   input wire [15:0] RDATA,
   input wire        TOGGLE_OUT,
   input wire        OVER_UNDER,
   input wire        TOGGLE_LATCH,
   input wire        SHADOW_LATCH,
   input wire        AUX_RUN
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   // control writes land in the outputs two edges later
   wire ctl_wr = WR && ADDR == 4'h1;
   rd_idle_a: assert property (!$past(RD) |-> RDATA == 16'h0000)
      else $error("read data not idle");
   unmapped_rd_a: assert property ($past(RD) && $past(ADDR) > 4'h4 |-> RDATA == 16'h0000)
      else $error("unmapped read not zero");
   wrap_pulse_a: assert property (OVER_UNDER |=> !OVER_UNDER)
      else $error("wrap pulse too long");
   shadow_lag_a: assert property (TOGGLE_LATCH != SHADOW_LATCH |=> SHADOW_LATCH == $past(TOGGLE_LATCH))
      else $error("shadow not one clock behind");
   sw_latch_a: assert property (ctl_wr |-> ##2 TOGGLE_LATCH == $past(WDATA[9], 2) && SHADOW_LATCH == TOGGLE_LATCH)
      else $error("latch write left an edge");
   out_high_a: assert property (ctl_wr && !WDATA[10] |-> ##2 TOGGLE_OUT)
      else $error("disabled toggle pin not high");
   out_show_a: assert property (ctl_wr && WDATA[10] |-> ##2 TOGGLE_OUT == TOGGLE_LATCH)
      else $error("toggle pin not showing latch");
   aux_run_a: assert property ($changed(AUX_RUN) |-> $past(WR, 2))
      else $error("aux run moved without a write");
endmodule // core_timer_chk
bind core_timer core_timer_chk u_core_timer_chk (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TOGGLE_OUT(TOGGLE_OUT),
   .OVER_UNDER(OVER_UNDER), .TOGGLE_LATCH(TOGGLE_LATCH), .SHADOW_LATCH(SHADOW_LATCH),
   .AUX_RUN(AUX_RUN));

// File: tb/pin_source.sv
// external count and gate pin source
`timescale 1ns/100ps
module pin_source #(
   parameter HOLD = 4
) (
   input  wire clk,
   input  wire want,
   output reg  pin
);
   integer held = 0;
   // a new level waits until the old one stood long enough to be seen
   always @(posedge clk) begin
      if (pin !== want && held >= HOLD) begin
         pin <= want;
         held <= 0;
      end else begin
         held <= held + 1;
      end
   end
   initial pin = 1'b0;
endmodule // pin_source

// File: tb/test_core_timer.sv
// self-checking bench for the core timer
`timescale 1ns/100ps
module test_core_timer;
   reg         clk = 0, arst_n = 0, wr = 0, rd = 0, want = 0, eud = 0, seen = 0, cap = 0;
   reg  [3:0]  addr = 4'h0;
   reg  [15:0] wdata = 16'h0000, v, a;
   reg  [7:0]  rnd = 8'h4D;
   wire [15:0] rdata;
   wire        tin, tout, ou, tl, sl, aux;
   integer     miscompares = 0, n_checks = 0, k, m, e;
   always #10 clk = ~clk;
   // wrap pulses last one cycle, so latch them for later checking
   always @(posedge clk) if (ou) seen <= 1'b1;
   core_timer u_core_timer (.CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .TIMER_IN(tin), .EXT_UPDOWN(eud), .CAPTURE_IN(cap),
      .TOGGLE_OUT(tout), .OVER_UNDER(ou), .TOGGLE_LATCH(tl), .SHADOW_LATCH(sl), .AUX_RUN(aux));
   pin_source u_pin_source (.clk(clk), .want(want), .pin(tin));
   function [7:0] lfsr(input [7:0] s);
      lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task chk16(input [15:0] g, input [15:0] x);
      begin
         n_checks = n_checks + 1;
         if (g !== x) begin
            miscompares = miscompares + 1;
            $display("MISMATCH %0t got %h exp %h", $time, g, x);
         end
      end
   endtask
   task wr_reg(input [3:0] ai, input [15:0] d);
      begin
         @(posedge clk);
         addr <= ai;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task rd_reg(input [3:0] ai);
      begin
         @(posedge clk);
         addr <= ai;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1 v = rdata;
      end
   endtask
   // two reads exactly 64 cycles apart give the step count
   task meas(input [15:0] c, input integer x);
      begin
         wr_reg(4'h1, c);
         repeat (8) @(posedge clk);
         rd_reg(4'h0);
         a = v;
         repeat (62) @(posedge clk);
         rd_reg(4'h0);
         chk16(v - a, x[15:0]);
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", n_checks, miscompares);
         if (miscompares == 0 && n_checks > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   initial begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      rd_reg(4'h1);
      chk16(v, 16'h0000);
      chk16({15'h0000, tout}, 16'h0001);
      wr_reg(4'h0, 16'h8000);
      for (k = 0; k < 4; k = k + 1)
         meas({3'b000, k[1:0], 11'h040}, 16 >> (k ^ 1));
      for (k = 0; k < 4; k = k + 1) begin
         rnd = lfsr(rnd);
         eud <= rnd[0];
         e = k[1] ? rnd[0] ^ k[0] : k[0];
         meas({7'h04, k[1:0], 7'h40}, e ? -16 : 16);
      end
      meas(16'h0800, 0);
      $display("timer tests done");
      for (k = 0; k < 4; k = k + 1) begin
         want <= k[0];
         meas({10'h021, 2'b01, k[1], 3'h0}, k[1] == k[0] ? 16 : 0);
      end
      $display("gate tests done");
      for (k = 0; k < 4; k = k + 1) begin
         wr_reg(4'h1, {10'h021, 3'h1, k[2:0]});
         rd_reg(4'h0);
         a = v;
         for (m = 0; m < 4; m = m + 1) begin
            want <= ~want;
            repeat (8) @(posedge clk);
         end
         rd_reg(4'h0);
         chk16(v - a, k == 0 ? 0 : k == 3 ? 4 : 2);
      end
      $display("counter tests done");
      seen <= 1'b0;
      wr_reg(4'h4, 16'h1234);
      wr_reg(4'h0, 16'hFFFC);
      wr_reg(4'h1, 16'h2C40);
      repeat (30) @(posedge clk);
      rd_reg(4'h0);
      chk16(v & 16'hFF00, 16'h1200);
      chk16({15'h0000, tl}, 16'h0001);
      chk16({15'h0000, seen}, 16'h0001);
      wr_reg(4'h1, 16'h0400);
      repeat (3) @(posedge clk);
      chk16({14'h0000, tout, sl}, 16'h0000);
      $display("wrap tests done");
      wr_reg(4'h3, 16'h0400);
      wr_reg(4'h1, 16'h0040);
      repeat (3) @(posedge clk);
      chk16({15'h0000, aux}, 16'h0001);
      rd_reg(4'hF);
      chk16(v, 16'h0000);
      wr_reg(4'h2, 16'h5A5A);
      wr_reg(4'h3, 16'h0800);
      cap <= 1'b1;
      repeat (6) @(posedge clk);
      rd_reg(4'h4);
      chk16(v, 16'h5A5A);
      $display("aux and map tests done");
      end_sim;
   end
   // watchdog well beyond the roughly 1200 cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      miscompares = miscompares + 1;
      end_sim;
   end
endmodule // test_core_timer
